/* inc/pin_mux_pkg.sv */
// Package holding register map, field layout and mux codes for the pin block
package pin_mux_pkg;
  localparam logic [7:0] ADDR_PIN_OUTPUT_ENABLE  = 8'h44;
  localparam logic [7:0] ADDR_PIN_OUTPUT_VALUE   = 8'h45;
  localparam logic [7:0] ADDR_PIN_LEVEL_READBACK = 8'h46;
  localparam logic [7:0] ADDR_AUX_OUTPUT_CONFIG  = 8'h47;

  localparam logic [7:0] RESET_PIN_OUTPUT_ENABLE = 8'h00;
  localparam logic [7:0] RESET_PIN_OUTPUT_VALUE  = 8'h00;
  localparam logic [7:0] RESET_AUX_OUTPUT_CONFIG = 8'h00;
  localparam logic [7:0] RESET_PIN_LEVEL         = 8'h00;

  // Field layout of the aux output configuration register
  localparam int         FAST_PAD_BIT  = 7;
  localparam int         SOURCE_MSB    = 3;
  localparam logic [7:0] CONFIG_WMASK  = 8'h8F;

  // Pin bit positions, shared by enable, value and readback
  localparam int         PIN_CLOCK_OUT = 6;
  localparam logic [7:0] SCAN_PIN_MASK = 8'h0F;

  // Source select codes
  localparam logic [3:0] SRC_FLOAT0   = 4'h0;
  localparam logic [3:0] SRC_FLOAT1   = 4'h1;
  localparam logic [3:0] SRC_LOW      = 4'h2;
  localparam logic [3:0] SRC_HIGH     = 4'h3;
  localparam logic [3:0] SRC_TX_ENV   = 4'h4;
  localparam logic [3:0] SRC_TX_ACT   = 4'h5;
  localparam logic [3:0] SRC_LINK     = 4'h6;
  localparam logic [3:0] SRC_RX_ENV   = 4'h7;
  localparam logic [3:0] SRC_RX_ACT   = 4'h8;
  localparam logic [3:0] SRC_RX_BIT   = 4'h9;
endpackage : pin_mux_pkg

/* core/aux_source_mux.sv */
// Combinational source selector for the aux output pin
module aux_source_mux (
  // Selection
  input  wire logic [3:0] source_i,
  // Internal signals
  input  wire logic       tx_envelope_i,
  input  wire logic       tx_active_i,
  input  wire logic       generic_link_signal_i,
  input  wire logic       rx_envelope_i,
  input  wire logic       rx_active_i,
  input  wire logic       rx_bit_i,
  // Result
  output logic            level_o,
  output logic            drive_o
);
  // Code decode; unlisted codes float the pin
  always_comb begin
    level_o = 1'b0;
    drive_o = 1'b1;
    unique case (source_i)
      pin_mux_pkg::SRC_FLOAT0,
      pin_mux_pkg::SRC_FLOAT1: drive_o = 1'b0;
      pin_mux_pkg::SRC_LOW:    level_o = 1'b0;
      pin_mux_pkg::SRC_HIGH:   level_o = 1'b1;
      pin_mux_pkg::SRC_TX_ENV: level_o = tx_envelope_i;
      pin_mux_pkg::SRC_TX_ACT: level_o = tx_active_i;
      pin_mux_pkg::SRC_LINK:   level_o = generic_link_signal_i;
      // Only meaningful in Type A at 106 kBd
      pin_mux_pkg::SRC_RX_ENV: level_o = rx_envelope_i;
      pin_mux_pkg::SRC_RX_ACT: level_o = rx_active_i;
      pin_mux_pkg::SRC_RX_BIT: level_o = rx_bit_i;
      default:                 drive_o = 1'b0;
    endcase
  end
endmodule : aux_source_mux

/* core/pin_readback_and_signal_mux.sv */
// Pin readback, general pin drive and aux output multiplexer
module pin_readback_and_signal_mux (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  // Register port
  input  wire logic [7:0] reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  // Multi-purpose pins, bit order as readback
  input  wire logic [7:0] pin_in_i,
  output logic      [7:0] pin_out_o,
  output logic      [7:0] pin_oen_o,
  // Clock output function
  input  wire logic       clock_source_i,
  output logic            clock_output_active_o,
  // Nonvolatile boundary-scan enable
  input  wire logic       scan_enabled_i,
  // Internal signals for the aux output
  input  wire logic       tx_envelope_i,
  input  wire logic       tx_active_i,
  input  wire logic       generic_link_signal_i,
  input  wire logic       rx_envelope_i,
  input  wire logic       rx_active_i,
  input  wire logic       rx_bit_i,
  // Aux output pin and pad speed
  output logic            aux_output_pin_o,
  output logic            aux_output_pin_oen_o,
  output logic            fast_pad_select_o
);
  logic [7:0] pin_output_enable;
  logic [7:0] pin_output_value;
  logic [7:0] aux_output_config;
  logic [7:0] pin_sync1;
  logic [7:0] pin_level_readback;
  logic [7:0] next_pin_output_enable;
  logic [7:0] next_pin_output_value;
  logic [7:0] next_aux_output_config;
  logic [7:0] eff_enable;
  logic       aux_level;
  logic       aux_drive;

  // Register writes; reserved config bits stay zero
  always_comb begin
    next_pin_output_enable = pin_output_enable;
    next_pin_output_value  = pin_output_value;
    next_aux_output_config = aux_output_config;
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        pin_mux_pkg::ADDR_PIN_OUTPUT_ENABLE:
          next_pin_output_enable = reg_wdata_i;
        pin_mux_pkg::ADDR_PIN_OUTPUT_VALUE:
          next_pin_output_value = reg_wdata_i;
        pin_mux_pkg::ADDR_AUX_OUTPUT_CONFIG:
          next_aux_output_config =
            reg_wdata_i & pin_mux_pkg::CONFIG_WMASK;
        default: ;
      endcase
    end
  end

  // Register state; readback writes are ignored
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_output_enable <= pin_mux_pkg::RESET_PIN_OUTPUT_ENABLE;
      pin_output_value  <= pin_mux_pkg::RESET_PIN_OUTPUT_VALUE;
      aux_output_config <= pin_mux_pkg::RESET_AUX_OUTPUT_CONFIG;
      pin_sync1         <= pin_mux_pkg::RESET_PIN_LEVEL;
      pin_level_readback <= pin_mux_pkg::RESET_PIN_LEVEL;
    end else begin
      pin_output_enable <= next_pin_output_enable;
      pin_output_value  <= next_pin_output_value;
      aux_output_config <= next_aux_output_config;
      // Two stages since pin levels are asynchronous
      pin_sync1          <= pin_in_i;
      pin_level_readback <= pin_sync1;
    end
  end

  // Scan pins cannot be taken over while scan is on
  always_comb begin
    eff_enable = pin_output_enable;
    if (scan_enabled_i) begin
      eff_enable = pin_output_enable & ~pin_mux_pkg::SCAN_PIN_MASK;
    end
  end

  // Pin drive; clock pin carries the clock unless taken over
  always_comb begin
    pin_oen_o = ~eff_enable;
    pin_out_o = pin_output_value;
    clock_output_active_o = ~eff_enable[pin_mux_pkg::PIN_CLOCK_OUT];
    if (clock_output_active_o) begin
      pin_out_o[pin_mux_pkg::PIN_CLOCK_OUT] = clock_source_i;
      pin_oen_o[pin_mux_pkg::PIN_CLOCK_OUT] = 1'b0;
    end
  end

  // Read data; unmapped addresses read zero
  always_comb begin
    unique case (reg_addr_i)
      pin_mux_pkg::ADDR_PIN_OUTPUT_ENABLE:  reg_rdata_o = pin_output_enable;
      pin_mux_pkg::ADDR_PIN_OUTPUT_VALUE:   reg_rdata_o = pin_output_value;
      pin_mux_pkg::ADDR_PIN_LEVEL_READBACK: reg_rdata_o = pin_level_readback;
      pin_mux_pkg::ADDR_AUX_OUTPUT_CONFIG:  reg_rdata_o = aux_output_config;
      default:                              reg_rdata_o = 8'h00;
    endcase
  end

  // Source select decode
  aux_source_mux u_mux (
    .source_i              (aux_output_config[pin_mux_pkg::SOURCE_MSB:0]),
    .tx_envelope_i         (tx_envelope_i),
    .tx_active_i           (tx_active_i),
    .generic_link_signal_i (generic_link_signal_i),
    .rx_envelope_i         (rx_envelope_i),
    .rx_active_i           (rx_active_i),
    .rx_bit_i              (rx_bit_i),
    .level_o               (aux_level),
    .drive_o               (aux_drive)
  );

  // Aux pin; low enable means driving
  assign aux_output_pin_o     = aux_level;
  assign aux_output_pin_oen_o = ~aux_drive;
  // Faster pads raise peak supply current
  assign fast_pad_select_o =
    aux_output_config[pin_mux_pkg::FAST_PAD_BIT];
endmodule : pin_readback_and_signal_mux

/* bench/pin_mux_checker.sv */
// Assertion checker for the pin readback and aux output block
module pin_mux_checker (
  // Clock, reset, register port and pins
  input wire logic       clk_i, rstn_i, reg_wr_i, scan_enabled_i,
  input wire logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, pin_in_i,
  input wire logic [7:0] pin_out_o, pin_oen_o,
  // Clock function, aux sources and aux pin
  input wire logic       clock_source_i, clock_output_active_o,
  input wire logic       tx_envelope_i, tx_active_i, generic_link_signal_i,
  input wire logic       rx_envelope_i, rx_active_i, rx_bit_i,
  input wire logic       aux_output_pin_o, aux_output_pin_oen_o,
  input wire logic       fast_pad_select_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] en, val, cfg;
  logic [5:0] src;
  // Shadow registers, so outputs are tied to what software wrote
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      en <= 8'h00;
      val <= 8'h00;
      cfg <= 8'h00;
    end else if (reg_wr_i) begin
      if (reg_addr_i == 8'h44) en <= reg_wdata_i;
      if (reg_addr_i == 8'h45) val <= reg_wdata_i;
      if (reg_addr_i == 8'h47) cfg <= reg_wdata_i & 8'h8F;
    end
  end
  assign src = {rx_bit_i, rx_active_i, rx_envelope_i, generic_link_signal_i,
                tx_active_i, tx_envelope_i};
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // Sync stages must be past reset before the level is trusted
  sequence s_rb;
    reg_addr_i == 8'h46 && $past(rstn_i, 3);
  endsequence
  a_readback_sync: assert property (s_rb |->
    reg_rdata_o == $past(pin_in_i, 2)) else $error("readback wrong");
  a_cfg_read: assert property (reg_addr_i == 8'h47 |->
    reg_rdata_o == cfg) else $error("config read wrong");
  a_fast_pad: assert property (fast_pad_select_o == cfg[7])
    else $error("pad speed wrong");
  a_aux_float: assert property (cfg[3:0] inside {0, 1, [10:15]} |->
    aux_output_pin_oen_o) else $error("aux not floating");
  a_aux_fixed: assert property (cfg[3:1] == 3'h1 |->
    !aux_output_pin_oen_o && aux_output_pin_o == cfg[0])
    else $error("aux level wrong");
  a_aux_route: assert property (cfg[3:0] inside {[4:9]} |->
    !aux_output_pin_oen_o && aux_output_pin_o == src[cfg[3:0] - 4'h4])
    else $error("aux source wrong");
  a_pin_enable: assert property (pin_oen_o ==
    (~(en & (scan_enabled_i ? 8'hF0 : 8'hFF)) & 8'hBF))
    else $error("pin enable wrong");
  a_pin_value: assert property ({pin_out_o[7], pin_out_o[5:0]} ==
    {val[7], val[5:0]}) else $error("pin value wrong");
  a_clock_off: assert property (clock_output_active_o == !en[6] &&
    pin_out_o[6] == (en[6] ? val[6] : clock_source_i))
    else $error("clock pin wrong");
endmodule : pin_mux_checker

bind pin_readback_and_signal_mux pin_mux_checker pin_mux_checker_i (.*);

/* bench/testbench.sv */
// Self-checking bench for the pin readback and aux output block
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_i = 0, rstn_i = 0, reg_wr_i = 0, scan_enabled_i = 0;
  logic [7:0] reg_addr_i = '0, reg_wdata_i = '0, pin_in_i = '0;
  logic       clock_source_i = 0, tx_envelope_i = 0, tx_active_i = 0;
  logic       generic_link_signal_i = 0, rx_envelope_i = 0, rx_active_i = 0;
  logic       rx_bit_i = 0, look = 0, fast_pad_select_o;
  logic       clock_output_active_o, aux_output_pin_o, aux_output_pin_oen_o;
  logic [7:0] reg_rdata_o, pin_out_o, pin_oen_o, obs, v, en, val;
  logic [9:0] exp_q[$], e;
  logic [5:0] s;
  int         n_fail = 0, check_count = 0;
  always #50 clk_i = ~clk_i;
  pin_readback_and_signal_mux pin_readback_and_signal_mux_i (.*);
  // Expected {clock on, pad, oen, level}; level masked while floating
  // Clock pin is never taken over while this is used, so clock stays on
  function automatic logic [7:0] aux_exp(input logic [7:0] c,
                                         input logic [5:0] s);
    if (c[3:1] == 3'h1) return {4'h0, 1'b1, c[7], 1'b0, c[0]};
    if (c[3:0] inside {[4:9]})
      return {4'h0, 1'b1, c[7], 1'b0, s[c[3:0] - 4'h4]};
    return {4'h0, 1'b1, c[7], 2'h2};
  endfunction : aux_exp
  // Byte write, taken at the second edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  // Note an expected result; the watcher compares it at the falling edge
  task automatic chk(input logic [1:0] k, input logic [7:0] a, x);
    @(posedge clk_i);
    reg_addr_i <= a;
    exp_q.push_back({k, x});
    look <= 1'b1;
    @(posedge clk_i);
    look <= 1'b0;
  endtask : chk
  task automatic stop_test;
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  // Watcher: falling edge keeps clear of register updates
  always @(negedge clk_i) begin
    if (look) begin
      e = exp_q.pop_front();
      case (e[9:8])
        2'h0: obs = reg_rdata_o;
        2'h1: obs = {4'h0, clock_output_active_o, fast_pad_select_o,
                     aux_output_pin_oen_o,
                     aux_output_pin_o & ~aux_output_pin_oen_o};
        2'h2: obs = pin_oen_o;
        default: obs = pin_out_o;
      endcase
      check_count++;
      if (obs !== e[7:0]) begin
        n_fail++;
        $display("CHECK FAILED %0t kind %0d got %h", $time, e[9:8], obs);
      end
    end
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    n_fail++;
    stop_test;
  end
  initial begin
    void'($urandom(42302));
    repeat (10) @(posedge clk_i);
    rstn_i <= 1'b1;
    chk(0, 8'h44, 8'h00);
    chk(0, 8'h47, 8'h00);
    chk(2, 8'h00, 8'hBF);
    chk(0, 8'h50, 8'h00);
    // Random levels; write to the read-only place must not stick
    repeat (8) begin
      v = $urandom;
      pin_in_i <= v;
      repeat (2) @(posedge clk_i);
      wr(8'h46, ~v);
      chk(0, 8'h46, v);
    end
    // Every source code, reserved bits written as ones
    for (int c = 0; c < 16; c++) begin
      s = $urandom;
      v = {1'($urandom), 3'h7, 4'(c)};
      {rx_bit_i, rx_active_i, rx_envelope_i, generic_link_signal_i,
       tx_active_i, tx_envelope_i} <= s;
      wr(8'h47, v);
      chk(0, 8'h47, v & 8'h8F);
      chk(1, 8'h47, aux_exp(v, s));
    end
    repeat (6) begin
      en = $urandom;
      val = $urandom;
      scan_enabled_i <= 1'($urandom);
      clock_source_i <= 1'($urandom);
      wr(8'h44, en);
      wr(8'h45, val);
      chk(0, 8'h45, val);
      chk(2, 8'h00, ~(en & (scan_enabled_i ? 8'hF0 : 8'hFF)) & 8'hBF);
      chk(3, 8'h00, {val[7], en[6] ? val[6] : clock_source_i, val[5:0]});
    end
    // Mid-run reset must bring back the reset register values
    rstn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    chk(0, 8'h47, 8'h00);
    chk(2, 8'h00, 8'hBF);
    stop_test;
  end
endmodule : testbench
